// [design/ppo_cfg.svh]
// Offsets, field positions, reset values and bus answers of the pulse
// pattern output unit. Assumes byte addresses on a 32-bit register bus.
`ifndef PPO_CFG_SVH
`define PPO_CFG_SVH

// Register byte offsets, one aligned word each
`define PPO_OFF_EN_H 8'h00
`define PPO_OFF_EN_L 8'h04
`define PPO_OFF_OUT_H 8'h08
`define PPO_OFF_OUT_L 8'h0c
`define PPO_OFF_PD_H_A 8'h10
`define PPO_OFF_PD_H_B 8'h14
`define PPO_OFF_PD_L_A 8'h18
`define PPO_OFF_PD_L_B 8'h1c
`define PPO_OFF_TSEL 8'h20

// Trigger select fields, two bits per group
`define PPO_TSEL_G0 1:0
`define PPO_TSEL_G1 3:2
`define PPO_TSEL_G2 5:4
`define PPO_TSEL_G3 7:6

// Reset values
`define PPO_EN_RST 16'h0000
`define PPO_OUT_RST 16'h0000
`define PPO_PD_RST 16'h0000
`define PPO_TSEL_RST 8'hff
`define PPO_RSV_NIBBLE 4'hf

// AXI4-Lite answers
`define PPO_RESP_OKAY 2'b00
`define PPO_RESP_DECERR 2'b11

`endif

// [design/ppo_pkg.sv]
// Types shared by the pulse pattern output unit.
// Assumes ppo_cfg.svh holds every number.
`default_nettype none

package ppo_pkg;
  typedef enum logic [1:0] {PPO_WR_COLLECT, PPO_WR_RESP} ppo_wr_e;
  typedef enum logic [1:0] {PPO_RD_IDLE, PPO_RD_FETCH, PPO_RD_RESP} ppo_rd_e;
  typedef enum logic [3:0] {
    PPO_REG_NONE, PPO_REG_EN_H, PPO_REG_EN_L, PPO_REG_OUT_H, PPO_REG_OUT_L,
    PPO_REG_PD_H_ALL, PPO_REG_PD_H_UP, PPO_REG_PD_H_LO,
    PPO_REG_PD_L_ALL, PPO_REG_PD_L_UP, PPO_REG_PD_L_LO, PPO_REG_TSEL
  } ppo_reg_e;
endpackage

`default_nettype wire

// [design/ppo_ifs.sv]
// Internal carriers of the pulse pattern output unit: register access
// from the bus slave, and trigger selection. Single clock domain.
`timescale 1ns/1ps
`default_nettype none

interface ppo_bus_if #(parameter int ADDR_W = 8);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_ok;
  modport master (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface

interface ppo_trig_if;
  logic [7:0] sel;
  logic [3:0] match;
  logic [3:0] fire;
  modport sel_unit (input sel, match, output fire);
  modport user (output sel, match, input fire);
endinterface

`default_nettype wire

// [design/ppo_trig_sel.sv]
// Per-group output trigger selection of the pulse pattern output unit.
// Assumes compare-match pulses that are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none

module ppo_trig_sel (
  // Select fields in, group triggers out
  ppo_trig_if.sel_unit trg
);
  // Picks the compare match of the timer channel that a code names
  function automatic logic pick(input logic [1:0] code,
                                input logic [3:0] match);
    pick = match[code];
  endfunction

  // One selector per group; combinational so the load lands on the match
  for (genvar g = 0; g < 4; g++) begin : gen_grp
    assign trg.fire[g] = pick(trg.sel[2*g +: 2], trg.match); // R13 R15
  end
endmodule

`default_nettype wire

// [design/ppo_axil_slave.sv]
// AXI4-Lite slave front end of the pulse pattern output unit.
// Assumes the register side answers decode results in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ppo_cfg.svh"

module ppo_axil_slave
  import ppo_pkg::*;
#(parameter int ADDR_W = 8) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  ppo_bus_if.master bus
);
  ppo_wr_e wr_state, next_wr_state;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [7:0] wr_data, next_wr_data;
  logic wr_strb, next_wr_strb;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;
  ppo_rd_e rd_state, next_rd_state;
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Only the low byte lane carries register data
  assign bus.wr_en = (wr_state == PPO_WR_COLLECT) && aw_held && w_held;
  assign bus.wr_addr = wr_addr;
  assign bus.wr_data = wr_data;
  assign bus.wr_strb = wr_strb;
  assign bus.rd_addr = rd_addr;

  // Write channel: address and data taken in either order
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    case (wr_state)
      PPO_WR_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_aw_held = 1'b1;
          next_awready = 1'b0;
          next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_w_held = 1'b1;
          next_wready = 1'b0;
          next_wr_data = s_axi_wdata[7:0];
          next_wr_strb = s_axi_wstrb[0];
        end
        if (aw_held && w_held) begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bvalid = 1'b1;
          next_bresp = bus.wr_ok ? `PPO_RESP_OKAY : `PPO_RESP_DECERR;
          next_wr_state = PPO_WR_RESP;
        end
      end
      default: begin
        if (s_axi_bready) begin
          next_bvalid = 1'b0;
          next_awready = 1'b1;
          next_wready = 1'b1;
          next_wr_state = PPO_WR_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_state <= PPO_WR_COLLECT;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
      wr_strb <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPO_RESP_OKAY;
    end else begin
      wr_state <= next_wr_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // Read channel: one fetch cycle so the read data leave a register
  always_comb begin
    next_rd_state = rd_state;
    next_rd_addr = rd_addr;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    case (rd_state)
      PPO_RD_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          next_rd_addr = s_axi_araddr;
          next_arready = 1'b0;
          next_rd_state = PPO_RD_FETCH;
        end
      end
      PPO_RD_FETCH: begin
        next_rdata = {24'h000000, bus.rd_data};
        next_rresp = bus.rd_ok ? `PPO_RESP_OKAY : `PPO_RESP_DECERR;
        next_rvalid = 1'b1;
        next_rd_state = PPO_RD_RESP;
      end
      default: begin
        if (s_axi_rready) begin
          next_rvalid = 1'b0;
          next_arready = 1'b1;
          next_rd_state = PPO_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_state <= PPO_RD_IDLE;
      rd_addr <= '0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PPO_RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rd_addr <= next_rd_addr;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule

`default_nettype wire

// [design/ppo_top.sv]
// Data path of the pulse pattern output unit: next-data enables, output
// levels, next-data registers and per-group trigger loads, behind an
// AXI4-Lite register port.
// Assumes compare-match pulses from a timer on the same core clock, one
// cycle each, and a single asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ppo_cfg.svh"

// Notes on behaviour
// [R1] Enabled low bits copy their next data into output on group trigger.
// [R2] Disabled low bits keep their output level when the trigger fires.
// [R3] Output bits enabled for pulse output ignore CPU writes.
// [R4] High output bits ignore CPU writes while their enable is set.
// [R5] High output bits take CPU writes while their enable is clear.
// [R6] Enabled high output bits load high next data on every trigger.
// [R7] Enabled low output bits load low next data on every trigger.
// [R8] The sixteen output level bits drive the sixteen pulse outputs.
// [R9] Next-data addresses depend on whether paired groups share a trigger.
// [R10] Groups 2 and 3 sharing a trigger: all high next data at one word.
// [R11] Otherwise bits 15..12 and 11..8 sit at two separate words.
// [R12] Reserved nibbles in split layout read as ones, writes ignored.
// [R13] A group loads on the trigger chosen in the trigger select register.
// [R14] Enabled high bits copy high next data on trigger; others do not.
// [R15] Select codes 00 to 11 pick timer channel 0 to 3 compare match.
// [R16] Low next data maps the same way, keyed on groups 0 and 1.
// [R17] Data bits reset to zero; a trigger updates its whole group at once.
module ppo_top
  import ppo_pkg::*;
#(parameter int ADDR_W = 8) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,

  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,

  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // AXI4-Lite read address and data
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,

  // Timer compare matches, channels 3..0, one-cycle pulses
  input wire logic [3:0] cmp_match,

  // Pulse output pins
  output logic [15:0] pulse_out
);
  ppo_bus_if #(.ADDR_W(ADDR_W)) bus ();
  ppo_trig_if trg ();

  // Unit state: bit 15..8 is the high half, 7..0 the low half
  logic [15:0] next_enable_bits;
  logic [15:0] next_next_enable_bits;
  logic [15:0] out_level_bits;
  logic [15:0] next_out_level_bits;
  logic [15:0] pending_data_bits;
  logic [15:0] next_pending_data_bits;
  logic [7:0] trigger_select_reg;
  logic [7:0] next_trigger_select_reg;

  logic [15:0] fire_mask;
  logic [15:0] load_mask;
  logic shared_hi;
  logic shared_lo;
  ppo_reg_e wr_reg;
  ppo_reg_e rd_reg;

  // Maps a bus address onto a register, given the current pairing of
  // groups; the same map serves reads and writes so they never disagree
  function automatic ppo_reg_e decode(input logic [ADDR_W-1:0] addr,
                                      input logic sh_hi,
                                      input logic sh_lo);
    logic [ADDR_W-1:0] word;
    word = {addr[ADDR_W-1:2], 2'b00};
    decode = PPO_REG_NONE;
    if (word == ADDR_W'(`PPO_OFF_EN_H)) begin
      decode = PPO_REG_EN_H;
    end else if (word == ADDR_W'(`PPO_OFF_EN_L)) begin
      decode = PPO_REG_EN_L;
    end else if (word == ADDR_W'(`PPO_OFF_OUT_H)) begin
      decode = PPO_REG_OUT_H;
    end else if (word == ADDR_W'(`PPO_OFF_OUT_L)) begin
      decode = PPO_REG_OUT_L;
    end else if (word == ADDR_W'(`PPO_OFF_PD_H_A)) begin
      decode = sh_hi ? PPO_REG_PD_H_ALL : PPO_REG_PD_H_UP; // R9 R10 R11
    end else if (word == ADDR_W'(`PPO_OFF_PD_H_B) && !sh_hi) begin
      decode = PPO_REG_PD_H_LO; // R11
    end else if (word == ADDR_W'(`PPO_OFF_PD_L_A)) begin
      decode = sh_lo ? PPO_REG_PD_L_ALL : PPO_REG_PD_L_UP; // R16
    end else if (word == ADDR_W'(`PPO_OFF_PD_L_B) && !sh_lo) begin
      decode = PPO_REG_PD_L_LO; // R16
    end else if (word == ADDR_W'(`PPO_OFF_TSEL)) begin
      decode = PPO_REG_TSEL;
    end
  endfunction

  // Bus front end
  ppo_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
    .core_clk(core_clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .bus(bus.master)
  );

  // Trigger selection per group
  assign trg.sel = trigger_select_reg;
  assign trg.match = cmp_match;

  ppo_trig_sel u_trig (
    .trg(trg.sel_unit)
  );

  // A group's trigger covers its four bits together
  for (genvar g = 0; g < 4; g++) begin : gen_mask
    assign fire_mask[4*g +: 4] = {4{trg.fire[g]}}; // R17
  end
  assign load_mask = next_enable_bits & fire_mask;

  // Pairing of groups decides the next-data layout
  // A pairing change re-maps the words at once; stored bits are kept
  assign shared_hi = trigger_select_reg[`PPO_TSEL_G3] ==
                     trigger_select_reg[`PPO_TSEL_G2]; // R10
  assign shared_lo = trigger_select_reg[`PPO_TSEL_G1] ==
                     trigger_select_reg[`PPO_TSEL_G0]; // R16

  assign wr_reg = decode(bus.wr_addr, shared_hi, shared_lo);
  assign rd_reg = decode(bus.rd_addr, shared_hi, shared_lo);
  assign bus.wr_ok = (wr_reg != PPO_REG_NONE);
  assign bus.rd_ok = (rd_reg != PPO_REG_NONE);

  // Read data; split next-data words fill their unused nibble with ones
  // Unmapped words read as zero; the slave answers them with an error
  always_comb begin
    bus.rd_data = 8'h00;
    case (rd_reg)
      PPO_REG_EN_H: begin
        bus.rd_data = next_enable_bits[15:8];
      end

      PPO_REG_EN_L: begin
        bus.rd_data = next_enable_bits[7:0];
      end

      PPO_REG_OUT_H: begin
        bus.rd_data = out_level_bits[15:8];
      end

      PPO_REG_OUT_L: begin
        bus.rd_data = out_level_bits[7:0];
      end

      PPO_REG_PD_H_ALL: begin
        bus.rd_data = pending_data_bits[15:8]; // R10
      end

      PPO_REG_PD_H_UP: begin
        bus.rd_data = {pending_data_bits[15:12], `PPO_RSV_NIBBLE}; // R12
      end

      PPO_REG_PD_H_LO: begin
        bus.rd_data = {`PPO_RSV_NIBBLE, pending_data_bits[11:8]}; // R12
      end

      PPO_REG_PD_L_ALL: begin
        bus.rd_data = pending_data_bits[7:0]; // R16
      end

      PPO_REG_PD_L_UP: begin
        bus.rd_data = {pending_data_bits[7:4], `PPO_RSV_NIBBLE}; // R16
      end

      PPO_REG_PD_L_LO: begin
        bus.rd_data = {`PPO_RSV_NIBBLE, pending_data_bits[3:0]}; // R16
      end

      PPO_REG_TSEL: begin
        bus.rd_data = trigger_select_reg;
      end

      default: begin
        bus.rd_data = 8'h00;
      end
    endcase
  end

  // Next values. The trigger load and a CPU write to the output levels
  // touch disjoint bits (enabled versus disabled), so they never clash.
  // A write to next data in the trigger cycle lands after the old value
  // has been loaded, which is what software pacing on the match expects.
  always_comb begin
    next_next_enable_bits = next_enable_bits;
    next_pending_data_bits = pending_data_bits;
    next_trigger_select_reg = trigger_select_reg;

    // Trigger load, whole group in one cycle
    next_out_level_bits = (out_level_bits & ~load_mask) |
                          (pending_data_bits & load_mask); // R1 R2 R6 R7 R14

    if (bus.wr_en && bus.wr_strb) begin
      case (wr_reg)
        PPO_REG_EN_H: begin
          next_next_enable_bits[15:8] = bus.wr_data;
        end

        PPO_REG_EN_L: begin
          next_next_enable_bits[7:0] = bus.wr_data;
        end

        PPO_REG_OUT_H: begin
          next_out_level_bits[15:8] =
            (next_out_level_bits[15:8] & next_enable_bits[15:8]) |
            (bus.wr_data & ~next_enable_bits[15:8]); // R3 R4 R5
        end

        PPO_REG_OUT_L: begin
          next_out_level_bits[7:0] =
            (next_out_level_bits[7:0] & next_enable_bits[7:0]) |
            (bus.wr_data & ~next_enable_bits[7:0]); // R3
        end

        PPO_REG_PD_H_ALL: begin
          next_pending_data_bits[15:8] = bus.wr_data; // R10
        end

        PPO_REG_PD_H_UP: begin
          next_pending_data_bits[15:12] = bus.wr_data[7:4]; // R11 R12
        end

        PPO_REG_PD_H_LO: begin
          next_pending_data_bits[11:8] = bus.wr_data[3:0]; // R11 R12
        end

        PPO_REG_PD_L_ALL: begin
          next_pending_data_bits[7:0] = bus.wr_data; // R16
        end

        PPO_REG_PD_L_UP: begin
          next_pending_data_bits[7:4] = bus.wr_data[7:4]; // R16
        end

        PPO_REG_PD_L_LO: begin
          next_pending_data_bits[3:0] = bus.wr_data[3:0]; // R16
        end

        PPO_REG_TSEL: begin
          next_trigger_select_reg = bus.wr_data; // R13
        end

        default: begin
        end
      endcase
    end
  end

  // Unit registers. The select field resets to all ones, so both pairs
  // start shared and the next-data words open in eight-bit form
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      next_enable_bits <= `PPO_EN_RST; // R17
      out_level_bits <= `PPO_OUT_RST; // R17
      pending_data_bits <= `PPO_PD_RST; // R17
      trigger_select_reg <= `PPO_TSEL_RST;
    end else begin
      next_enable_bits <= next_next_enable_bits;
      out_level_bits <= next_out_level_bits;
      pending_data_bits <= next_pending_data_bits;
      trigger_select_reg <= next_trigger_select_reg;
    end
  end

  // Pins follow the output levels directly, no extra stage
  assign pulse_out = out_level_bits; // R8
endmodule

`default_nettype wire

// [verification/ppo_timer_model.sv]
// Timer stand-in: compare-match pulses of four channels.
// Assumes the core clock of the unit; each pulse lasts one cycle.
`timescale 1ns/1ps
`default_nettype none

module ppo_timer_model (
  // Clock
  input wire logic core_clk,
  // Compare matches, channels 3..0
  output logic [3:0] cmp_match
);
  initial cmp_match = 4'h0;

  // Optional wait, then a one-cycle pulse; idle level is low
  task automatic pulse(input logic [3:0] m, input int w);
    repeat (w) @(posedge core_clk);
    @(posedge core_clk);
    cmp_match <= m;
    @(posedge core_clk);
    cmp_match <= 4'h0;
  endtask
endmodule

`default_nettype wire

// [verification/ppo_top_properties.sv]
// Port checker of the pulse output unit.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module ppo_top_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trigger and pins
  input wire logic [3:0] cmp_match,
  input wire logic [15:0] pulse_out
);
  logic trig_any;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Any compare match this cycle
  assign trig_any = |cmp_match;

  // Pins move only after a trigger or a finished write
  property p_out_cause;
    !$stable(pulse_out) |-> $past(trig_any) || $rose(s_axi_bvalid);
  endproperty
  a_out_cause: assert property (p_out_cause)
    else $error("pulse output moved without cause");

  // Write answer comes two edges after a joint handshake
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late or early");

  // Write answer stands until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");

  // No new write accepted while an answer is pending
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy)
    else $error("write accepted during answer");

  // Read data two edges after the address
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late or early");

  // Read data stands until taken
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed before taken");

  // Registers are one byte wide; upper lanes stay zero
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_r_upper: assert property (p_r_upper)
    else $error("read data upper bits set");

  // Taken read frees the address channel at once
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done)
    else $error("read channel not freed");

  c_trig: cover property (trig_any ##1 !$stable(pulse_out));
  c_decerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
  c_slow_b: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind ppo_top ppo_top_chk ppo_top_chk_i (.*);

`default_nettype wire

// [verification/pulse_pattern_output_data_path_tb_top.sv]
// Bench of the pulse output unit: bus tasks, register model, timer
// stand-in, corner writes and random traffic.
// Assumes the checker binds itself to ppo_top.
`timescale 1ns/1ps
`default_nettype none

module pulse_pattern_output_data_path_tb_top;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [3:0] cmp_match;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] pulse_out, en = 16'h0, od = 16'h0, pd = 16'h0;
  logic [7:0] ts = 8'hff;
  int bad_count = 0, checks_done = 0;
  // Layout select first so the corner writes land in the split map
  logic [7:0] amap [10] = '{8'h20, 8'h00, 8'h04, 8'h08, 8'h0c,
                            8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
  logic [7:0] cdat [9] = '{8'he4, 8'hff, 8'h0f, 8'h00, 8'hff,
                           8'ha5, 8'h3c, 8'h5a, 8'hc3};

  always #2 core_clk = ~core_clk;

  ppo_top ppo_top_i (.*);
  ppo_timer_model ppo_timer_model_i (.core_clk(core_clk),
                                     .cmp_match(cmp_match));

  task automatic results();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %0t %s", $time, m);
      bad_count++;
    end
  endtask

  // A wait that runs out ends the run
  task automatic tmo();
    chk(32'h0, 32'h1, "wait limit");
    results();
  endtask

  // Write; bready rises after w cycles to stall the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input int w,
                     output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      if (n == w) s_axi_bready <= 1'h1;
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    if (n == 50) tmo();
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a, input int w,
                     output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      if (n == w) s_axi_rready <= 1'h1;
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    if (n == 50) tmo();
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Register model: applies a write, gives read value and answer
  function automatic logic [1:0] mdl(input logic w, input logic [7:0] a, d,
                                     input logic s, output logic [7:0] v);
    int k, j;
    logic sh, we;
    k = a[3] ? 0 : 8;
    j = a[2] ? 0 : 8;
    we = w && s;
    sh = a[3] ? ts[3:2] == ts[1:0] : ts[7:6] == ts[5:4];
    v = 8'h00;
    mdl = 2'h0;
    case (a)
      8'h00, 8'h04: begin
        if (we) en[j +: 8] = d;
        v = en[j +: 8];
      end
      8'h08, 8'h0c: begin
        if (we) od[j +: 8] = od[j +: 8] & en[j +: 8] | d & ~en[j +: 8];
        v = od[j +: 8];
      end
      8'h10, 8'h18: begin
        if (we && sh) pd[k +: 8] = d;
        if (we && !sh) pd[k + 4 +: 4] = d[7:4];
        v = sh ? pd[k +: 8] : {pd[k + 4 +: 4], 4'hf};
      end
      8'h14, 8'h1c: begin
        if (we && !sh) pd[k +: 4] = d[3:0];
        v = sh ? 8'h00 : {4'hf, pd[k +: 4]};
        if (sh) mdl = 2'h3;
      end
      8'h20: begin
        if (we) ts = d;
        v = ts;
      end
      default: mdl = 2'h3;
    endcase
  endfunction

  // Trigger model: enabled bits of each selected group load at once
  function automatic void mtrig(input logic [3:0] m);
    for (int g = 0; g < 4; g++)
      if (m[ts[2 * g +: 2]])
        od[4 * g +: 4] = od[4 * g +: 4] & ~en[4 * g +: 4]
                         | pd[4 * g +: 4] & en[4 * g +: 4];
  endfunction

  // One operation: 0 write, 1 read, 2 trigger; then pins compared
  task automatic step(input int op, input logic [7:0] a, d,
                      input logic [3:0] s);
    logic [1:0] r, er;
    logic [31:0] v;
    logic [7:0] ev;
    int w;
    w = $urandom_range(0, 3);
    v = $urandom;
    if (op == 0) begin
      er = mdl(1'h1, a, d, s[0], ev);
      axw(a, {v[31:8], d}, s, w, r);
      chk({30'h0, r}, {30'h0, er}, "write answer");
    end else if (op == 1) begin
      er = mdl(1'h0, a, 8'h00, 1'h0, ev);
      axr(a, w, v, r);
      chk({30'h0, r}, {30'h0, er}, "read answer");
      chk(v, {24'h0, ev}, "read data");
    end else begin
      mtrig(d[3:0]);
      ppo_timer_model_i.pulse(d[3:0], w);
    end
    #1;
    chk({16'h0, pulse_out}, {16'h0, od}, "pins");
  endtask

  initial begin
    void'($urandom(42568));
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    for (int i = 0; i < 10; i++) step(1, amap[i], 8'h00, 4'h0);
    for (int i = 0; i < 9; i++) step(0, amap[i], cdat[i], 4'h1);
    for (int i = 0; i < 10; i++) step(1, amap[i], 8'h00, 4'h0);
    for (int i = 0; i < 4; i++) step(2, 8'h00, 8'h01 << i, 4'h0);
    repeat (400)
      step($urandom_range(0, 2), amap[$urandom_range(0, 9)],
           8'($urandom), 4'($urandom));
    results();
  end
endmodule

`default_nettype wire
